// *** pkg/pct_pkg.sv ***
// Constants and types shared by the paired channel pulse timer
package pct_pkg;
  localparam int COUNT_W = 16;
  localparam int PRESC_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_POWER = 8'h00;
  localparam logic [7:0] OFF_MMODE = 8'h04;
  localparam logic [7:0] OFF_SMODE = 8'h08;
  localparam logic [7:0] OFF_MRELOAD = 8'h0c;
  localparam logic [7:0] OFF_SRELOAD = 8'h10;
  localparam logic [7:0] OFF_MCOUNT = 8'h14;
  localparam logic [7:0] OFF_SCOUNT = 8'h18;
  localparam logic [7:0] OFF_START = 8'h1c;
  localparam logic [7:0] OFF_STOP = 8'h20;
  localparam logic [7:0] OFF_ENSTAT = 8'h24;
  localparam logic [7:0] OFF_OUTCTL = 8'h28;
  localparam logic [7:0] OFF_CAPSTAT = 8'h2c;
  localparam logic [7:0] OFF_PRESC = 8'h30;

  // Field positions
  localparam int POWER_EN = 0;
  localparam int MODE_CKS_LSB = 0;
  localparam int MODE_EDGE_LO = 2;
  localparam int MODE_EDGE_HI = 3;
  localparam int MODE_PWM = 4;
  localparam int MMODE_W = 5;
  localparam int SMODE_W = 2;
  localparam int TRIG_MASTER = 0;
  localparam int TRIG_SLAVE = 1;
  localparam int OUT_VALUE = 0;
  localparam int OUT_EN = 1;
  localparam int OUT_POL = 2;
  localparam int OUT_MODE = 3;
  localparam int OUTCTL_W = 4;
  localparam int PRESC_CK1_LSB = 4;
  localparam int PRESC_FIELD_W = 4;

  // Clock select encodings
  localparam logic [1:0] CKS_CK0 = 2'b00;
  localparam logic [1:0] CKS_CK1 = 2'b10;

  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_WAIT = 2'b01,
    M_COUNT = 2'b10
  } mstate_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ARMED = 2'b01,
    S_COUNT = 2'b10
  } sstate_t;
endpackage

// *** pkg/channel_count_if.sv ***
// Control and status carried between the sequencer and one channel counter
`timescale 1ns/1ps
interface channel_count_if #(parameter int W = 16);
  logic clr;
  logic load;
  logic tick;
  logic run;
  logic [W-1:0] reloadValue;
  logic [W-1:0] count;

  modport ctl (output clr, load, tick, run, reloadValue, input count);
  modport cnt (input clr, load, tick, run, reloadValue, output count);
endinterface

// *** hw/pulse_channel_counter.sv ***
// One down-counter of a timer channel
`timescale 1ns/1ps
module pulse_channel_counter #(
  parameter int W = 16
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  channel_count_if.cnt ch // Counter control and value
);
  logic [W-1:0] count_reg;

  initial begin
    if (W < 2 || W > 32) begin
      $error("pulse_channel_counter: W out of range");
    end
  end

  // Load wins over counting; a stuck channel holds at zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
    end else if (ch.clr) begin
      count_reg <= '0;
    end else if (ch.load) begin
      count_reg <= ch.reloadValue;
    end else if (ch.tick && ch.run && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign ch.count = count_reg;
endmodule

// *** hw/paired_channel_pulse_timer.sv ***
// Paired master/slave timer channels for one-shot pulse and PWM output
// Summary of operation
// - Joint start enables both, master waits trigger
// - Start bits self-clear, always read zero
// - Pin edge or start loads master, counts
// - One-shot master zero: interrupt, wait retrigger
// - Master interrupt loads and starts slave
// - Output active tick after, inactive at zero
// - Counters readable; capture status unused; output writable
// - Joint stop clears enables, holds counts, output
// - Output enable cleared: pin shows written value
// - Power enable off resets whole unit
// - PWM period reload+1 ticks, duty slave/period
// - Slave zero 0%, slave >= period 100%
// - PWM master: start interrupts, reloads each zero
// - PWM slave: one-count, interrupt at zero
// - PWM output active tick after master interrupt
// - Slave reload transfers at master interrupt, master reload too in PWM
// - Master channel even up to 6, slave higher
// - Clock select 00 prescaled 0, 10 prescaled 1
// - Polarity bit 0 active high, 1 low
`timescale 1ns/1ps
module paired_channel_pulse_timer #(
  parameter int MASTER_CH = 0,
  parameter int SLAVE_CH = 1
) (
  input wire logic clk, // System clock, 125 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic masterTrigIn, // master_trigger_input pin
  output logic pulseOut, // pulse_output pin level
  output logic pulseOutEn, // Pin owned by timer, else port mode
  output logic masterIrq, // master_count_irq pulse
  output logic slaveIrq // slave_count_irq pulse
);
  localparam int W = pct_pkg::COUNT_W;

  initial begin
    if (MASTER_CH < 0 || MASTER_CH > 6 || MASTER_CH % 2 != 0) begin
      $error("paired_channel_pulse_timer: master must be 0, 2, 4 or 6");
    end
    if (SLAVE_CH <= MASTER_CH || SLAVE_CH > 7) begin
      $error("paired_channel_pulse_timer: slave must be above master");
    end
  end

  logic preadyReg;
  logic pslverrReg;
  logic [31:0] prdataReg;
  logic unitOnReg;
  logic [pct_pkg::MMODE_W-1:0] masterModeReg;
  logic [pct_pkg::SMODE_W-1:0] slaveModeReg;
  logic [W-1:0] masterReloadReg;
  logic [W-1:0] slaveReloadReg;
  logic [pct_pkg::OUTCTL_W-1:0] outCtlReg;
  logic [7:0] prescReg;
  logic [pct_pkg::PRESC_W-1:0] prescCntReg;
  logic masterEnReg;
  logic slaveEnReg;
  logic trigPrevReg;
  logic masterIrqReg;
  logic slaveIrqReg;
  logic pulseOutEnReg;
  pct_pkg::mstate_t mState;
  pct_pkg::mstate_t mStateNext;
  pct_pkg::sstate_t sState;
  pct_pkg::sstate_t sStateNext;

  channel_count_if #(.W(W)) mIf ();
  channel_count_if #(.W(W)) sIf ();

  pulse_channel_counter #(.W(W)) masterCounter (
    .clk(clk),
    .arst_n(arst_n),
    .ch(mIf)
  );

  pulse_channel_counter #(.W(W)) slaveCounter (
    .clk(clk),
    .arst_n(arst_n),
    .ch(sIf)
  );

  // Bus decode: a write lands on the edge that completes the access
  logic access;
  logic wr;
  logic wrStart;
  logic wrStop;
  logic startM;
  logic startS;
  logic stopM;
  logic stopS;
  logic mapped;

  assign access = psel && penable;
  assign wr = access && pwrite && preadyReg && unitOnReg;
  assign wrStart = wr && paddr == pct_pkg::OFF_START;
  assign wrStop = wr && paddr == pct_pkg::OFF_STOP;
  assign startM = wrStart && pwdata[pct_pkg::TRIG_MASTER];
  assign startS = wrStart && pwdata[pct_pkg::TRIG_SLAVE];
  assign stopM = wrStop && pwdata[pct_pkg::TRIG_MASTER];
  assign stopS = wrStop && pwdata[pct_pkg::TRIG_SLAVE];

  always_comb begin
    unique case (paddr)
      pct_pkg::OFF_POWER, pct_pkg::OFF_MMODE, pct_pkg::OFF_SMODE,
      pct_pkg::OFF_MRELOAD, pct_pkg::OFF_SRELOAD, pct_pkg::OFF_MCOUNT,
      pct_pkg::OFF_SCOUNT, pct_pkg::OFF_START, pct_pkg::OFF_STOP,
      pct_pkg::OFF_ENSTAT, pct_pkg::OFF_OUTCTL, pct_pkg::OFF_CAPSTAT,
      pct_pkg::OFF_PRESC: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Count clocks from the prescaler
  localparam int PRESC_W_T = pct_pkg::PRESC_W;
  logic [PRESC_W_T-1:0] mask0;
  logic [PRESC_W_T-1:0] mask1;
  logic tick0;
  logic tick1;
  logic tickM;
  logic tickS;

  assign mask0 = PRESC_W_T'((32'h1 << prescReg[pct_pkg::PRESC_FIELD_W-1:0]) - 32'h1);
  assign mask1 = PRESC_W_T'((32'h1 << prescReg[pct_pkg::PRESC_CK1_LSB +:
                  pct_pkg::PRESC_FIELD_W]) - 32'h1);
  assign tick0 = unitOnReg && (prescCntReg & mask0) == mask0;
  assign tick1 = unitOnReg && (prescCntReg & mask1) == mask1;
  assign tickM = masterModeReg[pct_pkg::MODE_CKS_LSB +: 2] == pct_pkg::CKS_CK1 ? tick1 : tick0;
  assign tickS = slaveModeReg[pct_pkg::MODE_CKS_LSB +: 2] == pct_pkg::CKS_CK1 ? tick1 : tick0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescCntReg <= '0;
    end else if (!unitOnReg) begin
      prescCntReg <= '0;
    end else begin
      prescCntReg <= prescCntReg + 1'b1;
    end
  end

  // Trigger pin edge detect: 00 falling, 01 rising, 1x both
  logic pinEdge;
  logic rise;
  logic fall;
  logic pwm;

  assign rise = masterTrigIn && !trigPrevReg;
  assign fall = !masterTrigIn && trigPrevReg;
  assign pwm = masterModeReg[pct_pkg::MODE_PWM];
  always_comb begin
    if (masterModeReg[pct_pkg::MODE_EDGE_HI]) begin
      pinEdge = rise || fall;
    end else if (masterModeReg[pct_pkg::MODE_EDGE_LO]) begin
      pinEdge = rise;
    end else begin
      pinEdge = fall;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trigPrevReg <= 1'b0;
    end else begin
      trigPrevReg <= masterTrigIn;
    end
  end

  // Master sequencer
  logic mLoad;
  logic mIrq;

  always_comb begin
    mStateNext = mState;
    mLoad = 1'b0;
    mIrq = 1'b0;
    unique case (mState)
      pct_pkg::M_IDLE: begin
        if (startM && pwm) begin
          mIrq = 1'b1;
          mLoad = 1'b1;
          mStateNext = pct_pkg::M_COUNT;
        end else if (startM) begin
          mStateNext = pct_pkg::M_WAIT;
        end
      end
      pct_pkg::M_WAIT: begin
        if (startM || pinEdge) begin
          mLoad = 1'b1;
          mStateNext = pct_pkg::M_COUNT;
        end
      end
      pct_pkg::M_COUNT: begin
        if (tickM && mIf.count == pct_pkg::COUNT_ZERO) begin
          mIrq = 1'b1;
          if (pwm) begin
            mLoad = 1'b1;
          end else begin
            mStateNext = pct_pkg::M_WAIT;
          end
        end
      end
      default: mStateNext = pct_pkg::M_IDLE;
    endcase
    if (stopM) begin
      mStateNext = pct_pkg::M_IDLE;
      mLoad = 1'b0;
      mIrq = 1'b0;
    end
  end

  // Slave sequencer, started only by the master interrupt
  logic sLoad;
  logic sIrq;
  logic setActive;
  logic setInactive;

  always_comb begin
    sStateNext = sState;
    sLoad = 1'b0;
    sIrq = 1'b0;
    setActive = 1'b0;
    setInactive = 1'b0;
    unique case (sState)
      pct_pkg::S_IDLE: sStateNext = pct_pkg::S_IDLE;
      pct_pkg::S_ARMED: begin
        if (tickS && sIf.count != pct_pkg::COUNT_ZERO) begin
          setActive = 1'b1;
          sStateNext = pct_pkg::S_COUNT;
        end else if (tickS) begin
          setInactive = 1'b1;
          sIrq = 1'b1;
          sStateNext = pct_pkg::S_IDLE;
        end
      end
      pct_pkg::S_COUNT: begin
        if (tickS && sIf.count == pct_pkg::COUNT_ZERO) begin
          setInactive = 1'b1;
          sIrq = 1'b1;
          sStateNext = pct_pkg::S_IDLE;
        end
      end
      default: sStateNext = pct_pkg::S_IDLE;
    endcase
    // Reload on the zero tick still ends the pulse, else duty R of R+1 reads 100%
    if (mIrq && slaveEnReg) begin
      sLoad = 1'b1;
      sStateNext = pct_pkg::S_ARMED;
    end
    if (stopS) begin
      sStateNext = pct_pkg::S_IDLE;
      sLoad = 1'b0;
      sIrq = 1'b0;
      setActive = 1'b0;
      setInactive = 1'b0;
    end
  end

  // Master reload moves at the master interrupt in PWM, slave always
  assign mIf.clr = !unitOnReg;
  assign mIf.load = mLoad;
  assign mIf.tick = tickM;
  assign mIf.run = mState == pct_pkg::M_COUNT;
  assign mIf.reloadValue = masterReloadReg;
  assign sIf.clr = !unitOnReg;
  assign sIf.load = sLoad;
  assign sIf.tick = tickS;
  assign sIf.run = sState != pct_pkg::S_IDLE;
  assign sIf.reloadValue = slaveReloadReg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mState <= pct_pkg::M_IDLE;
      sState <= pct_pkg::S_IDLE;
    end else if (!unitOnReg) begin
      mState <= pct_pkg::M_IDLE;
      sState <= pct_pkg::S_IDLE;
    end else begin
      mState <= mStateNext;
      sState <= sStateNext;
    end
  end

  // Enable status: stop wins over start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      masterEnReg <= 1'b0;
      slaveEnReg <= 1'b0;
    end else if (!unitOnReg) begin
      masterEnReg <= 1'b0;
      slaveEnReg <= 1'b0;
    end else begin
      if (stopM) begin
        masterEnReg <= 1'b0;
      end else if (startM) begin
        masterEnReg <= 1'b1;
      end
      if (stopS) begin
        slaveEnReg <= 1'b0;
      end else if (startS) begin
        slaveEnReg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      masterIrqReg <= 1'b0;
      slaveIrqReg <= 1'b0;
    end else begin
      masterIrqReg <= mIrq;
      slaveIrqReg <= sIrq;
    end
  end

  // Configuration registers; power-off clears all but the power bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unitOnReg <= 1'b0;
    end else if (access && pwrite && preadyReg && paddr == pct_pkg::OFF_POWER) begin
      unitOnReg <= pwdata[pct_pkg::POWER_EN];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      masterModeReg <= '0;
      slaveModeReg <= '0;
      masterReloadReg <= '0;
      slaveReloadReg <= '0;
      prescReg <= '0;
    end else if (!unitOnReg) begin
      masterModeReg <= '0;
      slaveModeReg <= '0;
      masterReloadReg <= '0;
      slaveReloadReg <= '0;
      prescReg <= '0;
    end else if (wr) begin
      unique case (paddr)
        pct_pkg::OFF_MMODE: masterModeReg <= pwdata[pct_pkg::MMODE_W-1:0];
        pct_pkg::OFF_SMODE: slaveModeReg <= pwdata[pct_pkg::SMODE_W-1:0];
        pct_pkg::OFF_MRELOAD: masterReloadReg <= pwdata[W-1:0];
        pct_pkg::OFF_SRELOAD: slaveReloadReg <= pwdata[W-1:0];
        pct_pkg::OFF_PRESC: prescReg <= pwdata[7:0];
        default: prescReg <= prescReg;
      endcase
    end
  end

  // Output control; hardware owns the level only while enabled
  logic hwOut;
  assign hwOut = outCtlReg[pct_pkg::OUT_EN] && outCtlReg[pct_pkg::OUT_MODE];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outCtlReg <= '0;
    end else if (!unitOnReg) begin
      outCtlReg <= '0;
    end else begin
      if (wr && paddr == pct_pkg::OFF_OUTCTL) begin
        outCtlReg[pct_pkg::OUT_EN] <= pwdata[pct_pkg::OUT_EN];
        outCtlReg[pct_pkg::OUT_POL] <= pwdata[pct_pkg::OUT_POL];
        outCtlReg[pct_pkg::OUT_MODE] <= pwdata[pct_pkg::OUT_MODE];
        if (!outCtlReg[pct_pkg::OUT_EN]) begin
          outCtlReg[pct_pkg::OUT_VALUE] <= pwdata[pct_pkg::OUT_VALUE];
        end
      end
      // Hardware level change wins over a same-cycle software write
      if (hwOut && setActive) begin
        outCtlReg[pct_pkg::OUT_VALUE] <= !outCtlReg[pct_pkg::OUT_POL];
      end else if (hwOut && setInactive) begin
        outCtlReg[pct_pkg::OUT_VALUE] <= outCtlReg[pct_pkg::OUT_POL];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulseOutEnReg <= 1'b0;
    end else begin
      pulseOutEnReg <= unitOnReg && outCtlReg[pct_pkg::OUT_MODE];
    end
  end

  // APB answer: ready one cycle into the access phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
    end else begin
      preadyReg <= access && !preadyReg;
      pslverrReg <= access && !preadyReg && !mapped;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdataReg <= pct_pkg::RESET_WORD;
    end else if (access && !preadyReg && !pwrite) begin
      prdataReg <= pct_pkg::RESET_WORD;
      unique case (paddr)
        pct_pkg::OFF_POWER: prdataReg[pct_pkg::POWER_EN] <= unitOnReg;
        pct_pkg::OFF_MMODE: prdataReg[pct_pkg::MMODE_W-1:0] <= masterModeReg;
        pct_pkg::OFF_SMODE: prdataReg[pct_pkg::SMODE_W-1:0] <= slaveModeReg;
        pct_pkg::OFF_MRELOAD: prdataReg[W-1:0] <= masterReloadReg;
        pct_pkg::OFF_SRELOAD: prdataReg[W-1:0] <= slaveReloadReg;
        pct_pkg::OFF_MCOUNT: prdataReg[W-1:0] <= mIf.count;
        pct_pkg::OFF_SCOUNT: prdataReg[W-1:0] <= sIf.count;
        pct_pkg::OFF_ENSTAT: begin
          prdataReg[pct_pkg::TRIG_MASTER] <= masterEnReg;
          prdataReg[pct_pkg::TRIG_SLAVE] <= slaveEnReg;
        end
        pct_pkg::OFF_OUTCTL: prdataReg[pct_pkg::OUTCTL_W-1:0] <= outCtlReg;
        pct_pkg::OFF_PRESC: prdataReg[7:0] <= prescReg;
        // Start, stop and capture status always read zero
        default: prdataReg <= pct_pkg::RESET_WORD;
      endcase
    end
  end

  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = pslverrReg;
  assign pulseOut = outCtlReg[pct_pkg::OUT_VALUE];
  assign pulseOutEn = pulseOutEnReg;
  assign masterIrq = masterIrqReg;
  assign slaveIrq = slaveIrqReg;
endmodule

// *** sim/pct_monitor.sv ***
// Port checker for the paired channel pulse timer
`timescale 1ns/1ps
module pct_monitor (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic masterTrigIn, // Trigger pin
  input wire logic pulseOut, // Pulse pin
  input wire logic pulseOutEn, // Pin owned by timer
  input wire logic masterIrq, // Master interrupt
  input wire logic slaveIrq // Slave interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic rdDone = psel && penable && pready && !pwrite;
  wire logic badAddr = paddr > pct_pkg::OFF_PRESC || paddr[1:0] != 2'b00;

  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_map; pready |-> pslverr == badAddr; endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
  property p_trig_zero;
    rdDone && (paddr == pct_pkg::OFF_START || paddr == pct_pkg::OFF_STOP) |-> prdata == 32'h0;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger bits read nonzero");
  property p_cap_zero; rdDone && paddr == pct_pkg::OFF_CAPSTAT |-> prdata == 32'h0; endproperty
  a_cap_zero: assert property (p_cap_zero) else $error("capture status nonzero");
  property p_power_off;
    wrDone && paddr == pct_pkg::OFF_POWER && !pwdata[0] |-> ##3 (!pulseOutEn && !pulseOut);
  endproperty
  a_power_off: assert property (p_power_off) else $error("pin kept after power off");
  property p_mirq_pulse; masterIrq |=> !masterIrq; endproperty
  a_mirq_pulse: assert property (p_mirq_pulse) else $error("master irq too long");
  property p_sirq_pulse; slaveIrq |=> !slaveIrq; endproperty
  a_sirq_pulse: assert property (p_sirq_pulse) else $error("slave irq too long");
  // Two edges of slack: an event at the commit edge may still report
  property p_stop_quiet;
    wrDone && paddr == pct_pkg::OFF_STOP && pwdata[1:0] == 2'b11
      |-> ##3 (!masterIrq && !slaveIrq && $stable(pulseOut))[*2];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("activity after stop");
endmodule

bind paired_channel_pulse_timer pct_monitor pct_monitor_inst (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .masterTrigIn(masterTrigIn),
  .pulseOut(pulseOut), .pulseOutEn(pulseOutEn), .masterIrq(masterIrq), .slaveIrq(slaveIrq));

// *** sim/pct_pin_model.sv ***
// Far side: trigger pin driver and pulse pin observer
`timescale 1ns/1ps
module pct_pin_model (
  input wire logic clk, // Clock
  input wire logic fire, // Raise the trigger pin
  input wire logic clr, // Clear the high count
  input wire logic pulseOut, // Pulse pin level
  output logic masterTrigIn, // Trigger pin, pulled low when idle
  output int highCount // Cycles seen high
);
  initial masterTrigIn = 1'b0;
  always @(posedge clk) begin
    masterTrigIn <= fire;
    highCount <= clr ? 0 : highCount + int'(pulseOut === 1'b1);
  end
endmodule

// *** sim/tb_paired_channel_pulse_timer.sv ***
// Self-checking bench for the paired channel pulse timer
`timescale 1ns/1ps
module tb_paired_channel_pulse_timer;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, masterTrigIn, pulseOut, pulseOutEn, masterIrq, slaveIrq;
  logic fire = 1'b0;
  logic clr = 1'b1;
  logic [31:0] rdVal;
  logic rdErr;
  int highCount;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int mIrqs = 0;
  int sIrqs = 0;

  paired_channel_pulse_timer paired_channel_pulse_timer_inst (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .masterTrigIn(masterTrigIn),
    .pulseOut(pulseOut), .pulseOutEn(pulseOutEn), .masterIrq(masterIrq), .slaveIrq(slaveIrq));
  pct_pin_model pct_pin_model_inst (.clk(clk), .fire(fire), .clr(clr), .pulseOut(pulseOut),
    .masterTrigIn(masterTrigIn), .highCount(highCount));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Idle edge first so psel is never set and cleared in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdVal, exp);
  endtask

  task automatic measure(input int n, input int exp);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    check(32'(highCount), 32'(exp));
  endtask

  task automatic t_unpowered();
    wr(pct_pkg::OFF_MRELOAD, 32'h5);
    rd(pct_pkg::OFF_MRELOAD, 32'h0);
    rd(8'h40, 32'h0);
    check(rdErr, 1'b1);
    check(pulseOutEn, 1'b0);
  endtask

  task automatic t_oneshot();
    int m0;
    int s0;
    wr(pct_pkg::OFF_POWER, 32'h1);
    wr(pct_pkg::OFF_MMODE, 32'h4);
    wr(pct_pkg::OFF_MRELOAD, 32'h3);
    wr(pct_pkg::OFF_SRELOAD, 32'h2);
    wr(pct_pkg::OFF_OUTCTL, 32'ha);
    wr(pct_pkg::OFF_START, 32'h3);
    rd(pct_pkg::OFF_ENSTAT, 32'h3);
    rd(pct_pkg::OFF_START, 32'h0);
    rd(pct_pkg::OFF_CAPSTAT, 32'h0);
    m0 = mIrqs;
    s0 = sIrqs;
    repeat (6) @(posedge clk);
    check(32'(mIrqs - m0), 32'h0);
    fire <= 1'b1;
    measure(30, 2);
    fire <= 1'b0;
    check(32'(mIrqs - m0), 32'h1);
    wr(pct_pkg::OFF_START, 32'h1);
    measure(20, 2);
    check(32'(mIrqs - m0), 32'h2);
    check(32'(sIrqs - s0), 32'h2);
  endtask

  // Four periods after settling; high count is phase independent
  task automatic t_pwm(input int d, input logic pol, input logic ck1);
    int k;
    int act;
    k = ck1 ? 2 : 1;
    act = (d > 5 ? 5 : d) * 4 * k;
    wr(pct_pkg::OFF_STOP, 32'h3);
    wr(pct_pkg::OFF_PRESC, 32'h10);
    wr(pct_pkg::OFF_MMODE, ck1 ? 32'h12 : 32'h10);
    wr(pct_pkg::OFF_SMODE, ck1 ? 32'h2 : 32'h0);
    wr(pct_pkg::OFF_MRELOAD, 32'h4);
    wr(pct_pkg::OFF_SRELOAD, 32'(d));
    wr(pct_pkg::OFF_OUTCTL, pol ? 32'he : 32'ha);
    wr(pct_pkg::OFF_START, 32'h3);
    repeat (15) @(posedge clk);
    measure(20 * k, pol ? 20 * k - act : act);
  endtask

  task automatic t_stop();
    logic [31:0] held;
    wr(pct_pkg::OFF_STOP, 32'h3);
    rd(pct_pkg::OFF_ENSTAT, 32'h0);
    held = rdVal;
    xfer(1'b0, pct_pkg::OFF_MCOUNT, 32'h0);
    held = rdVal;
    repeat (5) @(posedge clk);
    rd(pct_pkg::OFF_MCOUNT, held);
    // Value bit is locked while the enable is set, so drop the enable first
    wr(pct_pkg::OFF_OUTCTL, 32'h8);
    wr(pct_pkg::OFF_OUTCTL, 32'h9);
    repeat (2) @(posedge clk);
    check(pulseOut, 1'b1);
    wr(pct_pkg::OFF_OUTCTL, 32'h8);
    repeat (2) @(posedge clk);
    check(pulseOut, 1'b0);
    wr(pct_pkg::OFF_OUTCTL, 32'h9);
    wr(pct_pkg::OFF_POWER, 32'h0);
    repeat (3) @(posedge clk);
    check({pulseOutEn, pulseOut}, 2'b00);
    rd(pct_pkg::OFF_OUTCTL, 32'h0);
    rd(pct_pkg::OFF_SRELOAD, 32'h0);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    mIrqs <= mIrqs + int'(masterIrq === 1'b1);
    sIrqs <= sIrqs + int'(slaveIrq === 1'b1);
    if (cycles == 6000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_unpowered();
    t_oneshot();
    t_pwm(2, 1'b0, 1'b0);
    t_pwm(0, 1'b0, 1'b0);
    t_pwm(4, 1'b0, 1'b0);
    t_pwm(5, 1'b0, 1'b0);
    t_pwm(7, 1'b0, 1'b0);
    t_pwm(2, 1'b1, 1'b0);
    t_pwm(2, 1'b0, 1'b1);
    t_stop();
    finish_test();
  end
endmodule
